//--- src/tw_regs.svh
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

// register offsets on the plain register port
`define TW_OFF_CTRL 8'h00
`define TW_OFF_DATA 8'h04
`define TW_OFF_STATUS 8'h08
`define TW_OFF_OWN 8'h0c
`define TW_OFF_IRQ_STAT 8'h10
`define TW_OFF_IRQ_CLR 8'h14
`define TW_OFF_IRQ_EN 8'h18

// serial_control_reg bit positions
`define TW_CTRL_START 0
`define TW_CTRL_STOP 1
`define TW_CTRL_FLAG 2
`define TW_CTRL_ACK 3
`define TW_CTRL_ENABLE 4

// interrupt status, clear and enable bit positions
`define TW_EV_STATUS 0
`define TW_EV_BUSERR 1
`define TW_EV_ARBLOST 2

// reset values
`define TW_RST_OWN 8'h00
`define TW_RST_IRQ_EN 3'h0
`define TW_RST_STATUS 8'hf8

// status codes
`define TW_SC_BUSERR 8'h00
`define TW_SC_START 8'h08
`define TW_SC_RSTART 8'h10
`define TW_SC_MT_AACK 8'h18
`define TW_SC_MT_ANACK 8'h20
`define TW_SC_MT_DACK 8'h28
`define TW_SC_MT_DNACK 8'h30
`define TW_SC_ARBLOST 8'h38
`define TW_SC_MR_AACK 8'h40
`define TW_SC_MR_ANACK 8'h48
`define TW_SC_MR_DACK 8'h50
`define TW_SC_MR_DNACK 8'h58
`define TW_SC_SR_ADDR 8'h60
`define TW_SC_SR_ADDR_AL 8'h68
`define TW_SC_SR_GC 8'h70
`define TW_SC_SR_GC_AL 8'h78
`define TW_SC_SR_DACK 8'h80
`define TW_SC_SR_DNACK 8'h88
`define TW_SC_SR_GDACK 8'h90
`define TW_SC_SR_GDNACK 8'h98
`define TW_SC_SR_STOP 8'ha0

// timing: a quarter of a bus bit period, least time rounded up
`define TW_CLK_NS 100
`define TW_QUARTER_NS 2500
`define TW_QUARTER_CYC ((`TW_QUARTER_NS + `TW_CLK_NS - 1) / `TW_CLK_NS)

`endif

//--- src/tw_pkg.sv
package tw_pkg;

	// master sequencer states
	typedef enum logic [2:0] {
		MS_IDLE,
		MS_FREE_WAIT,
		MS_START,
		MS_BYTE,
		MS_WAIT,
		MS_STOP,
		MS_LOST
	} tw_mstate_t;

endpackage

//--- src/tw_sync.sv
`timescale 1ns/1ps
module tw_sync #(
	parameter int W = 2
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] ff1;
	logic [W-1:0] ff2;
	logic [W-1:0] ff3;

	// three stages; idle bus lines are high, so reset to ones
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ff1 <= '1;
			ff2 <= '1;
			ff3 <= '1;
		end else begin
			ff1 <= d;
			ff2 <= ff1;
			ff3 <= ff2;
		end
	end

	// a bit moves only once the last two stages agree, which filters a glitch
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '1;
		end else begin
			q <= (ff2 & ff3) | (q & (ff2 ^ ff3));
		end
	end
endmodule

//--- src/tw_tick.sv
`timescale 1ns/1ps
module tw_tick #(
	parameter int CYC = 25
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic run,
	output logic tick
);
	localparam int W = $clog2(CYC + 1);
	logic [W-1:0] cnt;

	// one-cycle enable every CYC cycles while running
	assign tick = run && (cnt == W'(CYC - 1));

	// restarts from zero whenever the sequencer stops, so phases stay aligned
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt <= '0;
		end else if (!run || tick) begin
			cnt <= '0;
		end else begin
			cnt <= W'(cnt + 1'b1);
		end
	end
endmodule

//--- src/tw_top.sv
`timescale 1ns/1ps
`include "tw_regs.svh"
// Overview of operation
// - status register holds an 8-bit code, refreshed whenever the flag is set.
// - after START code 08h; software loads read address and clears flag.
// - at 10h a read address is sent as read, write address switches over.
// - at 38h clearing flag without start releases bus, becomes idle slave.
// - at 38h clearing flag with start waits for free bus, then STARTs.
// - at 40h next byte is received, ack enable picks ACK or NOT ACK.
// - in receive states ack enable at flag clear sets the next answer.
// - at 48h or 58h start alone gives a repeated START.
// - at 48h or 58h stop alone gives STOP, then stop bit self-clears.
// - at 48h or 58h start and stop give STOP then START, stop clears.
// - at 50h software reads data; next byte acknowledged per ack enable.
// - slave: own write address 60h, acked bytes 80h, STOP/START A0h.
// - slave: last byte answered NOT ACK reports 88h.
// - general call 70h, acked bytes 90h, NOT ACK byte 98h.
// - addressed after lost arbitration reports 68h, or 78h for general call.
// - at 60h, 68h, 70h flag clear receives a byte, ack per ack enable.
// - bus error reports 00h; stop plus flag clear releases lines, clears stop.
module tw_top #(
	parameter int QUARTER_CYC = `TW_QUARTER_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe
);
	logic [1:0] pins_s;
	logic scl_s, sda_s, scl_p, sda_p;
	logic scl_rise, scl_fall, start_det, stop_det, bus_busy;
	logic start_req, stop_req, flag, ack_en, enable, gc_en;
	logic [6:0] own_addr;
	logic [7:0] data_reg, status, next_status;
	logic [2:0] irq_stat, irq_en;
	logic ctrl_wr, go, set_flag, buserr_ev;
	tw_pkg::tw_mstate_t mstate;
	logic [1:0] phase;
	logic [3:0] bitn;
	logic [7:0] m_shift, m_code;
	logic m_tx, m_addr, m_read, m_ack, m_own, m_then_start;
	logic m_scl_low, m_sda_low, m_post, m_post_rx, stop_clr, arb_ev;
	logic tick, run, bit_val, al, s_act;
	logic [3:0] s_cnt;
	logic [7:0] s_shift, s_code;
	logic s_adr_phase, s_addr, s_gc, s_hit, s_ack;
	logic s_scl_low, s_sda_low, s_post, s_post_rx;

	tw_sync #(.W(2)) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.d({scl_in, sda_in}),
		.q(pins_s)
	);

	tw_tick #(.CYC(QUARTER_CYC)) u_tick (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.run(run),
		.tick(tick)
	);

	// open-drain lines: only ever pull low
	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = m_scl_low | s_scl_low;
	assign sda_oe = m_sda_low | s_sda_low;

	// bus conditions seen on the filtered lines
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_det = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

	// previous line levels and bus-free tracking
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
			bus_busy <= 1'b0;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
			if (start_det) begin
				bus_busy <= 1'b1;
			end else if (stop_det) begin
				bus_busy <= 1'b0;
			end
		end
	end

	// software hands the bus back by writing the flag bit as zero
	assign ctrl_wr = reg_wr && (reg_addr == `TW_OFF_CTRL);
	assign go = ctrl_wr && flag && !reg_wdata[`TW_CTRL_FLAG] && !set_flag;
	assign set_flag = m_post | s_post;
	assign next_status = m_post ? m_code : s_code;
	assign buserr_ev = m_post && (m_code == `TW_SC_BUSERR);
	assign al = (mstate == tw_pkg::MS_LOST);
	assign s_act = enable && (mstate == tw_pkg::MS_IDLE || al ||
		mstate == tw_pkg::MS_FREE_WAIT);
	assign run = mstate == tw_pkg::MS_START || mstate == tw_pkg::MS_BYTE ||
		mstate == tw_pkg::MS_STOP;
	assign bit_val = (bitn < 4'd8) ? (m_tx ? m_shift[7] : 1'b1) :
		(m_tx ? 1'b1 : ~m_ack);

	// control bits; a hardware clear of stop loses to a software write
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			start_req <= 1'b0;
			stop_req <= 1'b0;
			ack_en <= 1'b0;
			enable <= 1'b0;
		end else if (ctrl_wr) begin
			start_req <= reg_wdata[`TW_CTRL_START];
			stop_req <= reg_wdata[`TW_CTRL_STOP];
			ack_en <= reg_wdata[`TW_CTRL_ACK];
			enable <= reg_wdata[`TW_CTRL_ENABLE];
		end else if (stop_clr) begin
			stop_req <= 1'b0;
		end
	end

	// flag and status code; a new code wins over a software clear
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag <= 1'b0;
			status <= `TW_RST_STATUS;
		end else if (set_flag) begin
			flag <= 1'b1;
			status <= next_status;
		end else if (ctrl_wr && !reg_wdata[`TW_CTRL_FLAG]) begin
			flag <= 1'b0;
		end
	end

	// address setup and data byte, shared by master and slave paths
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			data_reg <= 8'h00;
			own_addr <= 7'(`TW_RST_OWN >> 1);
			gc_en <= 1'b0;
		end else begin
			if (reg_wr && reg_addr == `TW_OFF_OWN) begin
				own_addr <= reg_wdata[7:1];
				gc_en <= reg_wdata[0];
			end
			if (reg_wr && reg_addr == `TW_OFF_DATA) begin
				data_reg <= reg_wdata;
			end else if (m_post_rx) begin
				data_reg <= m_shift;
			end else if (s_post_rx) begin
				data_reg <= s_shift;
			end
		end
	end

	// sticky events; a set in the clearing cycle survives
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat <= 3'h0;
			irq_en <= `TW_RST_IRQ_EN;
		end else begin
			if (reg_wr && reg_addr == `TW_OFF_IRQ_EN) begin
				irq_en <= reg_wdata[2:0];
			end
			irq_stat <= (irq_stat & ~((reg_wr && reg_addr == `TW_OFF_IRQ_CLR) ?
				reg_wdata[2:0] : 3'h0)) | {arb_ev, buserr_ev, set_flag};
		end
	end
	assign irq = |(irq_stat & irq_en);

	// read data stand only in the cycle after the read strobe
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`TW_OFF_CTRL: reg_rdata <= {3'h0, enable, ack_en, flag,
					stop_req, start_req};
				`TW_OFF_DATA: reg_rdata <= data_reg;
				`TW_OFF_STATUS: reg_rdata <= status;
				`TW_OFF_OWN: reg_rdata <= {own_addr, gc_en};
				`TW_OFF_IRQ_STAT: reg_rdata <= {5'h00, irq_stat};
				`TW_OFF_IRQ_EN: reg_rdata <= {5'h00, irq_en};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// master sequencer: quarter-bit phases, stretching waits in phase 1
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			mstate <= tw_pkg::MS_IDLE;
			phase <= 2'd0;
			bitn <= 4'd0;
			m_shift <= 8'h00;
			m_code <= 8'h00;
			{m_tx, m_addr, m_read, m_ack, m_own, m_then_start} <= 6'h00;
			{m_scl_low, m_sda_low, m_post, m_post_rx} <= 4'h0;
			stop_clr <= 1'b0;
			arb_ev <= 1'b0;
		end else begin
			m_post <= 1'b0;
			m_post_rx <= 1'b0;
			stop_clr <= 1'b0;
			arb_ev <= 1'b0;
			if (go && (mstate == tw_pkg::MS_WAIT ||
				mstate == tw_pkg::MS_IDLE)) begin
				phase <= 2'd0;
				bitn <= 4'd0;
				case (status)
					`TW_SC_START, `TW_SC_RSTART: begin
						m_shift <= data_reg;
						m_read <= data_reg[0];
						m_tx <= 1'b1;
						m_addr <= 1'b1;
						mstate <= tw_pkg::MS_BYTE;
					end
					`TW_SC_MT_AACK, `TW_SC_MT_ANACK, `TW_SC_MT_DACK,
					`TW_SC_MT_DNACK, `TW_SC_MR_ANACK, `TW_SC_MR_DNACK: begin
						if (reg_wdata[`TW_CTRL_STOP]) begin
							m_then_start <= reg_wdata[`TW_CTRL_START];
							mstate <= tw_pkg::MS_STOP;
						end else if (reg_wdata[`TW_CTRL_START]) begin
							mstate <= tw_pkg::MS_START;
						end else if (status == `TW_SC_MR_ANACK ||
							status == `TW_SC_MR_DNACK) begin
							m_then_start <= 1'b0;
							mstate <= tw_pkg::MS_STOP;
						end else begin
							m_shift <= data_reg;
							m_tx <= 1'b1;
							m_addr <= 1'b0;
							mstate <= tw_pkg::MS_BYTE;
						end
					end
					`TW_SC_MR_AACK, `TW_SC_MR_DACK: begin
						m_tx <= 1'b0;
						m_ack <= reg_wdata[`TW_CTRL_ACK];
						mstate <= tw_pkg::MS_BYTE;
					end
					`TW_SC_ARBLOST, `TW_SC_SR_DNACK, `TW_SC_SR_GDNACK,
					`TW_SC_SR_STOP: begin
						m_scl_low <= 1'b0;
						m_sda_low <= 1'b0;
						mstate <= reg_wdata[`TW_CTRL_START] ?
							tw_pkg::MS_FREE_WAIT : tw_pkg::MS_IDLE;
					end
					`TW_SC_BUSERR: begin
						m_scl_low <= 1'b0;
						m_sda_low <= 1'b0;
						m_own <= 1'b0;
						stop_clr <= 1'b1;
						mstate <= tw_pkg::MS_IDLE;
					end
					default: mstate <= tw_pkg::MS_IDLE;
				endcase
			end else begin
				unique case (mstate)
					tw_pkg::MS_IDLE: begin
						m_scl_low <= 1'b0;
						m_sda_low <= 1'b0;
						if (enable && start_req && !flag && !s_addr) begin
							mstate <= tw_pkg::MS_FREE_WAIT;
						end
					end
					tw_pkg::MS_FREE_WAIT: begin
						if (!bus_busy) begin
							phase <= 2'd0;
							mstate <= tw_pkg::MS_START;
						end
					end
					tw_pkg::MS_START: if (tick) begin
						unique case (phase)
							2'd0: begin
								m_sda_low <= 1'b0;
								phase <= 2'd1;
							end
							2'd1: begin
								m_scl_low <= 1'b0;
								if (scl_s && !m_scl_low) phase <= 2'd2;
							end
							2'd2: begin
								m_sda_low <= 1'b1;
								phase <= 2'd3;
							end
							2'd3: begin
								m_scl_low <= 1'b1;
								m_code <= m_own ? `TW_SC_RSTART : `TW_SC_START;
								m_post <= 1'b1;
								m_own <= 1'b1;
								mstate <= tw_pkg::MS_WAIT;
							end
						endcase
					end
					tw_pkg::MS_BYTE: begin
						if (start_det || stop_det) begin
							m_scl_low <= 1'b0;
							m_sda_low <= 1'b0;
							m_own <= 1'b0;
							m_code <= `TW_SC_BUSERR;
							m_post <= 1'b1;
							mstate <= tw_pkg::MS_WAIT;
						end else if (tick) begin
							unique case (phase)
								2'd0: begin
									m_sda_low <= ~bit_val;
									phase <= 2'd1;
								end
								2'd1: begin
									m_scl_low <= 1'b0;
									if (scl_s && !m_scl_low) phase <= 2'd2;
								end
								2'd2: begin
									phase <= 2'd3;
									if (bitn < 4'd8) begin
										m_shift <= {m_shift[6:0], sda_s};
									end else if (m_tx) begin
										m_ack <= ~sda_s;
									end
									if (bit_val && !sda_s &&
										(m_tx ? bitn < 4'd8 : bitn == 4'd8)) begin
										m_sda_low <= 1'b0;
										m_own <= 1'b0;
										arb_ev <= 1'b1;
										if (m_addr) begin
											mstate <= tw_pkg::MS_LOST;
										end else begin
											m_code <= `TW_SC_ARBLOST;
											m_post <= 1'b1;
											mstate <= tw_pkg::MS_IDLE;
										end
									end
								end
								2'd3: begin
									m_scl_low <= 1'b1;
									phase <= 2'd0;
									bitn <= 4'(bitn + 4'd1);
									if (bitn == 4'd8) begin
										m_post <= 1'b1;
										m_post_rx <= !m_tx;
										mstate <= tw_pkg::MS_WAIT;
										if (!m_tx) begin
											m_code <= m_ack ? `TW_SC_MR_DACK :
												`TW_SC_MR_DNACK;
										end else if (!m_addr) begin
											m_code <= m_ack ? `TW_SC_MT_DACK :
												`TW_SC_MT_DNACK;
										end else if (m_read) begin
											m_code <= m_ack ? `TW_SC_MR_AACK :
												`TW_SC_MR_ANACK;
										end else begin
											m_code <= m_ack ? `TW_SC_MT_AACK :
												`TW_SC_MT_ANACK;
										end
									end
								end
							endcase
						end
					end
					tw_pkg::MS_STOP: if (tick) begin
						unique case (phase)
							2'd0: begin
								m_sda_low <= 1'b1;
								phase <= 2'd1;
							end
							2'd1: begin
								m_scl_low <= 1'b0;
								if (scl_s && !m_scl_low) phase <= 2'd2;
							end
							2'd2: begin
								m_sda_low <= 1'b0;
								phase <= 2'd3;
							end
							2'd3: begin
								stop_clr <= 1'b1;
								m_own <= 1'b0;
								phase <= 2'd0;
								mstate <= m_then_start ? tw_pkg::MS_FREE_WAIT :
									tw_pkg::MS_IDLE;
							end
						endcase
					end
					tw_pkg::MS_WAIT: ;
					tw_pkg::MS_LOST: if (s_post) mstate <= tw_pkg::MS_IDLE;
				endcase
			end
		end
	end

	// slave receiver: snoops every byte, acts only when not mastering
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_cnt <= 4'd0;
			s_shift <= 8'h00;
			s_code <= 8'h00;
			{s_adr_phase, s_addr, s_gc, s_hit, s_ack} <= 5'h00;
			{s_scl_low, s_sda_low, s_post, s_post_rx} <= 4'h0;
		end else begin
			s_post <= 1'b0;
			s_post_rx <= 1'b0;
			if (start_det || stop_det) begin
				s_cnt <= 4'd0;
				s_adr_phase <= start_det;
				s_sda_low <= 1'b0;
				s_hit <= 1'b0;
				if (s_addr && s_act) begin
					s_addr <= 1'b0;
					s_code <= `TW_SC_SR_STOP;
					s_post <= 1'b1;
				end
			end else if (scl_rise && s_cnt < 4'd9) begin
				if (s_cnt < 4'd8) s_shift <= {s_shift[6:0], sda_s};
				s_cnt <= 4'(s_cnt + 4'd1);
			end else if (scl_fall && s_cnt == 4'd8 && s_act) begin
				if (s_adr_phase) begin
					if (ack_en && ((s_shift[7:1] == own_addr && !s_shift[0]) ||
						(s_shift == 8'h00 && gc_en))) begin
						s_sda_low <= 1'b1;
						s_hit <= 1'b1;
						s_gc <= (s_shift == 8'h00);
						s_ack <= ack_en;
					end else if (al) begin
						s_code <= `TW_SC_ARBLOST;
						s_post <= 1'b1;
					end
				end else if (s_addr) begin
					s_sda_low <= s_ack;
				end
			end else if (scl_fall && s_cnt == 4'd9) begin
				s_cnt <= 4'd0;
				s_adr_phase <= 1'b0;
				s_sda_low <= 1'b0;
				if (s_hit) begin
					s_hit <= 1'b0;
					s_addr <= 1'b1;
					s_scl_low <= 1'b1;
					s_post <= 1'b1;
					s_code <= s_gc ? (al ? `TW_SC_SR_GC_AL : `TW_SC_SR_GC) :
						(al ? `TW_SC_SR_ADDR_AL : `TW_SC_SR_ADDR);
				end else if (s_addr && s_act) begin
					s_addr <= s_ack;
					s_scl_low <= 1'b1;
					s_post <= 1'b1;
					s_post_rx <= 1'b1;
					s_code <= s_gc ? (s_ack ? `TW_SC_SR_GDACK : `TW_SC_SR_GDNACK) :
						(s_ack ? `TW_SC_SR_DACK : `TW_SC_SR_DNACK);
				end
			end
			if (go) begin
				s_scl_low <= 1'b0;
				s_ack <= reg_wdata[`TW_CTRL_ACK];
			end
		end
	end

	AST_STATUS_WITH_FLAG: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$changed(status) |-> flag) else $error("status moved without flag");
	AST_START_CODE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mstate == tw_pkg::MS_START && tick && phase == 2'd3) |-> ##2
		(flag && (status == `TW_SC_START || status == `TW_SC_RSTART)))
		else $error("START not reported");
	AST_ADDR_LOADED: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(go && (status == `TW_SC_START || status == `TW_SC_RSTART)) |=>
		(mstate == tw_pkg::MS_BYTE && m_tx && m_shift == $past(data_reg)))
		else $error("address not loaded");
	AST_LOST_RELEASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(go && status == `TW_SC_ARBLOST && !reg_wdata[`TW_CTRL_START]) |=>
		(mstate == tw_pkg::MS_IDLE && !m_scl_low && !m_sda_low))
		else $error("bus not released after 38h");
	AST_WAIT_FREE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mstate == tw_pkg::MS_FREE_WAIT && bus_busy) |=>
		(mstate == tw_pkg::MS_FREE_WAIT && !m_sda_low))
		else $error("START on busy bus");
	AST_ACK_DRIVE: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mstate == tw_pkg::MS_BYTE && !m_tx && bitn == 4'd8 && phase == 2'd1)
		|-> (m_sda_low == m_ack)) else $error("wrong ack answer");
	AST_STOP_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mstate == tw_pkg::MS_STOP && tick && phase == 2'd3) |-> ##2
		(!stop_req || $past(ctrl_wr))) else $error("stop bit not cleared");
	AST_STOP_THEN_START: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mstate == tw_pkg::MS_STOP && tick && phase == 2'd3 && m_then_start)
		|=> mstate == tw_pkg::MS_FREE_WAIT) else $error("no START after STOP");
	AST_SLAVE_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(s_post && (s_code == `TW_SC_SR_ADDR || s_code == `TW_SC_SR_GC)) |=>
		(flag && s_addr && s_scl_low)) else $error("slave address not taken");
	AST_BUSERR: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(mstate == tw_pkg::MS_BYTE && (start_det || stop_det)) |-> ##2
		(flag && status == `TW_SC_BUSERR)) else $error("bus error missed");
	AST_HOLD_SCL: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(flag && mstate == tw_pkg::MS_WAIT && status != `TW_SC_BUSERR) |->
		scl_oe) else $error("clock released while flag set");
	AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_b)
		(set_flag && irq_en[`TW_EV_STATUS] &&
		!(reg_wr && reg_addr == `TW_OFF_IRQ_EN)) |=> irq)
		else $error("interrupt not raised");
endmodule

//--- sim/tw_slave_model.sv
`timescale 1ns/1ps
// read-side bus slave; lines have pull-ups, so a release reads high
module tw_slave_model #(
	parameter logic [6:0] ADDR = 7'h52
) (
	input wire logic scl,
	input wire logic sda,
	input wire logic [7:0] tx_byte,
	input wire logic slow,
	output logic sda_low,
	output logic scl_low
);
	logic [7:0] sh;
	logic more;
	initial begin
		sda_low = 1'b0;
		scl_low = 1'b0;
	end
	// one frame per start; address match answered, read bytes sent
	always begin : frame
		@(negedge sda iff scl === 1'b1);
		for (int i = 0; i < 8; i++) begin
			@(posedge scl);
			sh = {sh[6:0], sda};
		end
		if (sh[7:1] == ADDR) begin
			@(negedge scl);
			sda_low = 1'b1;
			more = sh[0];
			@(negedge scl);
			sda_low = 1'b0;
			while (more) begin
				sh = tx_byte;
				for (int i = 0; i < 8; i++) begin
					sda_low = ~sh[7-i];
					// slow mode stretches one low phase
					if (slow && i == 4) begin
						scl_low = 1'b1;
						#1500;
						scl_low = 1'b0;
					end
					@(negedge scl);
				end
				sda_low = 1'b0;
				@(posedge scl);
				more = ~sda;
				@(negedge scl);
			end
		end
	end
	// a stop aborts whatever frame is running
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			disable frame;
			sda_low = 1'b0;
			scl_low = 1'b0;
		end
	end
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "tw_regs.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
	error_cnt++; $display("unexpected %s exp %h got %h", n, e, s); end end
module tb_top;
	logic sys_clk, rst_b, reg_wr, reg_rd, irq, rd_d, slow;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, tx, d0, d1, e;
	logic scl_out, scl_oe, sda_out, sda_oe, scl_low, sda_low;
	// pulls of the bench-side master, which talks to the slave receiver
	logic bscl, bsda, ak;
	wire scl = ~(scl_oe | scl_low | bscl);
	wire sda = ~(sda_oe | sda_low | bsda);
	int error_cnt = 0, total_checks = 0, cyc = 0;
	int seed = 32'h5781db5d;
	logic [7:0] exp_q[$];
	tw_top #(.QUARTER_CYC(2)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe));
	tw_slave_model #(.ADDR(7'h52)) slv (.scl(scl), .sda(sda),
		.tx_byte(tx), .slow(slow), .sda_low(sda_low), .scl_low(scl_low));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// an extra edge after each strobe keeps drivers from colliding
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(x);
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wait_irq;
		for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge sys_clk);
		`CHK("irq", 1'b1, irq)
	endtask
	// wait for the flag, then expect the code
	task automatic seen(input logic [7:0] s);
		wait_irq();
		wr(`TW_OFF_IRQ_CLR, 8'h01);
		rd(`TW_OFF_STATUS, s);
	endtask
	// hand the flag back, then expect the next code
	task automatic go(input logic [7:0] c, input logic [7:0] s);
		wr(`TW_OFF_CTRL, c);
		seen(s);
	endtask
	// bench master byte: 6 cycles low, 2 high, waits out stretching
	task automatic bb(input logic [7:0] b, output logic a);
		logic [8:0] v;
		v = {b, 1'b1};
		for (int i = 8; i >= 0; i--) begin
			@(posedge sys_clk);
			bsda <= ~v[i];
			repeat (5) @(posedge sys_clk);
			bscl <= 1'b0;
			do @(posedge sys_clk); while (!scl);
			a = sda;
			@(posedge sys_clk);
			bscl <= 1'b1;
		end
	endtask
	// START from idle lines, or STOP from a held-low clock
	task automatic bb_cond(input logic stop);
		bsda <= 1'b1;
		repeat (4) @(posedge sys_clk);
		bscl <= !stop;
		repeat (4) @(posedge sys_clk);
		bsda <= !stop;
		repeat (4) @(posedge sys_clk);
	endtask
	// read data is only valid in the cycle after the strobe
	always @(posedge sys_clk) begin
		rd_d <= reg_rd;
		if (rd_d) begin
			e = exp_q.pop_front();
			`CHK("rdata", e, reg_rdata)
		end
	end
	// hang guard, well above the expected run length
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		{reg_wr, reg_rd, slow, bscl, bsda} = 5'h00;
		{reg_addr, reg_wdata, tx} = 24'h000000;
		rst_b = 1'b0;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rd(`TW_OFF_STATUS, `TW_RST_STATUS);
		rd(`TW_OFF_CTRL, 8'h00);
		rd(8'h1c, 8'h00);
		`CHK("pins", 2'b00, {scl_out, sda_out})
		$display("test reset done");
		wr(`TW_OFF_IRQ_EN, 8'h01);
		wr(`TW_OFF_CTRL, 8'h11);
		wait_irq();
		wr(`TW_OFF_IRQ_EN, 8'h00);
		`CHK("masked", 1'b0, irq)
		wr(`TW_OFF_IRQ_EN, 8'h01);
		`CHK("unmasked", 1'b1, irq)
		`CHK("scl held", 1'b0, scl)
		wr(`TW_OFF_IRQ_CLR, 8'h01);
		`CHK("cleared", 1'b0, irq)
		rd(`TW_OFF_STATUS, `TW_SC_START);
		wr(`TW_OFF_DATA, 8'h67);
		go(8'h10, `TW_SC_MR_ANACK);
		go(8'h11, `TW_SC_RSTART);
		$display("test address done");
		d0 = 8'($random(seed));
		d1 = 8'($random(seed));
		tx = d0;
		slow = 1'b1;
		wr(`TW_OFF_DATA, 8'ha5);
		go(8'h10, `TW_SC_MR_AACK);
		tx = d1;
		go(8'h18, `TW_SC_MR_DACK);
		rd(`TW_OFF_DATA, d0);
		slow = 1'b0;
		go(8'h10, `TW_SC_MR_DNACK);
		rd(`TW_OFF_DATA, d1);
		go(8'h13, `TW_SC_START);
		$display("test read done");
		wr(`TW_OFF_DATA, 8'h67);
		go(8'h10, `TW_SC_MR_ANACK);
		wr(`TW_OFF_CTRL, 8'h12);
		for (int i = 0; i < 500 && !(scl && sda); i++) @(posedge sys_clk);
		repeat (4) @(posedge sys_clk);
		rd(`TW_OFF_CTRL, 8'h10);
		`CHK("lines free", 2'b11, {scl, sda})
		$display("test stop done");
		wr(`TW_OFF_OWN, 8'h60);
		wr(`TW_OFF_CTRL, 8'h18);
		bb_cond(1'b0);
		bb(8'h60, ak);
		seen(`TW_SC_SR_ADDR);
		`CHK("slave ack", 1'b0, ak)
		wr(`TW_OFF_CTRL, 8'h18);
		bb(d0, ak);
		seen(`TW_SC_SR_DACK);
		rd(`TW_OFF_DATA, d0);
		wr(`TW_OFF_CTRL, 8'h10);
		bb(d1, ak);
		seen(`TW_SC_SR_DNACK);
		`CHK("slave nack", 1'b1, ak)
		wr(`TW_OFF_CTRL, 8'h18);
		bb_cond(1'b1);
		bb_cond(1'b0);
		bb(8'h60, ak);
		seen(`TW_SC_SR_ADDR);
		wr(`TW_OFF_CTRL, 8'h18);
		bb_cond(1'b1);
		seen(`TW_SC_SR_STOP);
		wr(`TW_OFF_CTRL, 8'h18);
		$display("test slave done");
		final_report();
	end
endmodule
